// ---- testbench/dmis_host.sv ----
`timescale 1ns/1ns
module dmis_host
  import dmis_pkg::*;
(
  input wire logic mclk,
  output dmis_req_t req,
  input wire logic ack,
  input wire logic rvalid,
  input wire logic [15:0] rdata
);
  initial req = '0;
  // One-cycle pulse; the answer is taken on the edge after it is accepted
  task automatic xfer(input logic w, pm, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q, output logic ok);
    @(posedge mclk) req <= '{w, !w, pm, 8'hff, a, d};
    @(posedge mclk) req <= '0;
    @(posedge mclk) q = rdata;
    ok = ack && rvalid == !w;
  endtask
endmodule

// ---- testbench/dmis_props.sv ----
`timescale 1ns/1ns
module dmis_props
  import dmis_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire dmis_req_t req,
  input wire logic [3:0] gpi_function,
  input wire logic gpi_enable,
  input wire logic gpio_in,
  input wire logic serial_out_line,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic ack,
  input wire dmis_ctrl_t ctrl,
  input wire dmis_safe_cmd_t safe_cmd,
  input wire logic gpio_out,
  input wire logic gpio_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Armed protect pin seeing a falling edge
  sequence fall_s;
    gpi_enable && gpi_function == 4'h5 && $past(gpio_in) && !gpio_in;
  endsequence
  // Registered answer on the next edge, one action only
  sequence fire_s;
    ##1 safe_cmd.fire && $onehot({safe_cmd.jump_nvm, safe_cmd.slew_low,
      safe_cmd.slew_high, safe_cmd.hiz_now});
  endsequence
  req_ack_a: assert property (ack == $past(req.wr || req.rd)) else $error("ack");
  read_valid_a: assert property (rvalid == $past(req.rd)) else $error("rvalid");
  rdata_idle_a: assert property (!rvalid |-> rdata == 16'h0000) else $error("rdata");
  prot_fire_a: assert property (fall_s |-> fire_s) else $error("fire");
  fire_cause_a: assert property (safe_cmd.fire |-> $past(gpi_enable && !gpio_in))
    else $error("spurious fire");
  sdo_gate_a: assert property (gpio_out |-> gpio_oe) else $error("sdo gate");
  sdo_follow_a: assert property (gpio_oe |-> gpio_out == $past(serial_out_line))
    else $error("sdo data");
  reset_clear_a: assert property ($fell(rst) |-> ctrl == '0 && !gpio_oe)
    else $error("reset");
endmodule

// ---- testbench/dmis_regs_tb_top.sv ----
`timescale 1ns/1ns
module dmis_regs_tb_top;
  import dmis_pkg::*;
  logic mclk = 0, rst = 1, gpi_enable = 0, gpio_in = 1, serial_out_line = 0;
  logic rvalid, ack, ok, gpio_out, gpio_oe;
  logic [3:0] gpi_function = 4'h0;
  logic [15:0] rdata, q, m, i, w[3];
  logic [7:0] p, ad[4] = '{8'h25, 8'h26, 8'h2b, 8'h30};
  dmis_req_t req;
  dmis_ctrl_t ctrl;
  dmis_safe_cmd_t safe_cmd;
  int err_count = 0, checked = 0, cyc = 0;
  dmis_regs dut (.*);
  dmis_host host (.*);
  always #25 mclk = ~mclk;
  // Random serial stream, plus the hang guard
  always @(posedge mclk) begin
    serial_out_line <= 1'($urandom());
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.xfer(1, 0, a, d, q, ok);
    chk("wr ack", 16'(ok), 1);
  endtask
  task automatic rd(input logic pm, input logic [7:0] a);
    host.xfer(0, pm, a, 0, q, ok);
  endtask
  // Control levels expected from the two settings words
  function automatic logic [15:0] exp_ctrl(input logic [15:0] m, i);
    return {11'h0, m[13], i[12], i[8], i[2], i[0]};
  endfunction
  initial begin
    void'($urandom(86));
    repeat (8) @(posedge mclk);
    rst <= 0;
    foreach (ad[k]) begin
      rd(0, ad[k]);
      chk("rst", q, 0);
    end
    repeat (6) begin
      m = 16'($urandom()) & 16'h2300;
      i = 16'($urandom());
      wr(8'h25, m);
      wr(8'h26, i);
      @(posedge mclk);
      #1 chk("ctrl", 16'(ctrl), exp_ctrl(m, i));
      chk("oe", 16'(gpio_oe), 16'(i[0]));
      chk("sdo", 16'(gpio_out), i[0] ? 16'(gpio_out) : 16'h0);
      rd(0, 8'h26);
      chk("iface", q, i & 16'h1105);
    end
    // Last pass uses a foreign pin function and must stay quiet
    gpi_enable <= 1;
    for (int a = 0; a < 5; a++) begin
      wr(8'h25, {6'h0, 2'(a), 8'h0});
      gpi_function <= a < 4 ? 4'h5 : 4'h4;
      @(posedge mclk) gpio_in <= 0;
      @(posedge mclk);
      #1 chk("safe", 16'(safe_cmd), a < 4 ?
        {11'h0, 1'b1, a == 1, a == 2, a == 3, a == 0} : 16'h0);
      @(posedge mclk) gpio_in <= 1;
    end
    wr(8'h26, 16'h0100);
    for (int k = 0; k < 2; k++) begin
      p = k ? 8'($urandom()) : 8'hfe;
      wr(8'h2b, {8'h0, p});
      foreach (w[j]) begin
        w[j] = 16'($urandom());
        wr(8'h2c, w[j]);
      end
      rd(1, 8'hef);
      chk("ptr", q, {8'h0, p + 8'd3});
      foreach (w[j]) begin
        wr(8'h2b, {8'h0, p + 8'(j)});
        rd(j[0], j[0] ? 8'hf0 : 8'h2c);
        chk("data", q, w[j]);
      end
    end
    close_out();
  end
endmodule
bind dmis_regs dmis_props props (.*);

// ---- verilog/dmis_defs.svh ----
`ifndef DMIS_DEFS_SVH
`define DMIS_DEFS_SVH

// Register addresses (I2C/SPI space)
`define DMIS_ADDR_MODE 8'h25
`define DMIS_ADDR_IFACE 8'h26
`define DMIS_ADDR_PTR 8'h2b
`define DMIS_ADDR_DATA 8'h2c
// PMBus page and command codes
`define DMIS_PM_PAGE 8'hff
`define DMIS_PM_CMD_MODE 8'he9
`define DMIS_PM_CMD_PTR 8'hef
`define DMIS_PM_CMD_DATA 8'hf0
// Reset values
`define DMIS_RST_MODE 16'h0000
`define DMIS_RST_IFACE 16'h0000
`define DMIS_RST_PTR 16'h0000
// Field positions
`define DMIS_LOWPWR_BIT 13
`define DMIS_PROT_HI 9
`define DMIS_PROT_LO 8
`define DMIS_TIMEOUT_BIT 12
`define DMIS_PMBUS_BIT 8
`define DMIS_FSDO_BIT 2
`define DMIS_SDO_BIT 0
// Writable masks of the interface register
`define DMIS_IFACE_MASK 16'h1105
// GPIO input function code for the protect input
`define DMIS_GPI_PROTECT 4'h5

`endif

// ---- verilog/dmis_pkg.sv ----
package dmis_pkg;

  typedef enum logic [1:0] {
    DMIS_SAFE_HIZ,
    DMIS_SAFE_NVM,
    DMIS_SAFE_MLOW,
    DMIS_SAFE_MHIGH
  } dmis_safe_t;

  // Host access request from the protocol engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic pmbus;
    logic [7:0] page;
    logic [7:0] addr;
    logic [15:0] wdata;
  } dmis_req_t;

  // Controls handed to the rest of the device
  typedef struct packed {
    logic low_power_select;
    logic timeout_active;
    logic pmbus_active;
    logic fast_serial_out_enable;
    logic serial_out_enable;
  } dmis_ctrl_t;

  // Safe-state command on a protect event
  typedef struct packed {
    logic fire;
    logic jump_nvm;
    logic slew_low;
    logic slew_high;
    logic hiz_now;
  } dmis_safe_cmd_t;

endpackage

// ---- verilog/dmis_regs.sv ----
`timescale 1ns/1ns
`include "dmis_defs.svh"
// What this block does
// - Low-power bit selects reduced consumption; clear keeps normal; resets zero.
// - Safe action 00: protect goes straight to Hi-Z power-down, no slew.
// - Safe action 01: jump to stored code, no slew, then Hi-Z.
// - Safe action 10 slews to margin-low, 11 to margin-high, then Hi-Z.
// - PMBus enable bit only drives pmbus_active; the page FFh decode here works whatever its value.
// - Fast serial-out timing used only while its bit is one.
// - Serial data out driven on GPIO only while its bit is one.
// - Writing the 8-bit pointer selects the next data-port location.
// - Pointer increments by one after every data-port write.
// - Data-port write stores at pointer; read returns word there.
// - Interface register at 26h, resets to 0000h, all disabled.
// - PMBus page FFh reaches pointer at EFh and data at F0h.
// - Protect-input GPIO: falling edge fires the safe action; high does nothing.
module dmis_regs
  import dmis_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire dmis_req_t req,
  input wire logic [3:0] gpi_function,
  input wire logic gpi_enable,
  input wire logic gpio_in,
  input wire logic serial_out_line,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic ack,
  output dmis_ctrl_t ctrl,
  output dmis_safe_cmd_t safe_cmd,
  output logic gpio_out,
  output logic gpio_oe
);

  logic [15:0] mode_reg;
  logic [15:0] next_mode_reg;
  logic [15:0] iface_reg;
  logic [15:0] next_iface_reg;
  logic [AW-1:0] ptr;
  logic [AW-1:0] next_ptr;
  logic [15:0] mem [DEPTH];
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic next_ack;
  dmis_ctrl_t next_ctrl;
  dmis_safe_cmd_t next_safe_cmd;
  logic gpio_q;
  logic next_gpio_q;
  logic next_gpio_out;
  logic next_gpio_oe;
  logic hit_mode;
  logic hit_iface;
  logic hit_ptr;
  logic hit_data;
  logic data_wr;
  logic [DEPTH-1:0] word_we;
  dmis_safe_t action;
  logic mode_wr;
  logic iface_wr;
  logic ptr_wr;
  logic protect_armed;
  logic pin_fall;

  // Notes for users of this bank:
  // - requests are one-cycle pulses; a request held high is taken again
  // - a data write and a pointer write cannot share a cycle, one address each
  // - a pointer read returns its eight bits with the upper bits zero
  // - memory words are not cleared by reset and read unknown until written
  // - the protect pin is sampled on mclk and must idle high
  // - the interface word has no PMBus command and is reached directly only
  // - every answer comes one cycle after its request, unmapped ones too
  // - the safe-state command is a one-cycle pulse per falling edge
  // - the partner logic turns the command into slews and power-down

  // Address decode, either register space or PMBus page/command
  always_comb begin
    hit_mode = 1'b0;
    hit_iface = 1'b0;
    hit_ptr = 1'b0;
    hit_data = 1'b0;
    if (req.pmbus) begin
      if (req.page == `DMIS_PM_PAGE) begin
        hit_mode = (req.addr == `DMIS_PM_CMD_MODE);
        hit_ptr = (req.addr == `DMIS_PM_CMD_PTR);
        hit_data = (req.addr == `DMIS_PM_CMD_DATA);
      end
    end else begin
      hit_mode = (req.addr == `DMIS_ADDR_MODE);
      hit_iface = (req.addr == `DMIS_ADDR_IFACE);
      hit_ptr = (req.addr == `DMIS_ADDR_PTR);
      hit_data = (req.addr == `DMIS_ADDR_DATA);
    end
  end

  // Write strobes; reads never touch stored state
  always_comb begin
    mode_wr = req.wr && hit_mode;
    iface_wr = req.wr && hit_iface;
    ptr_wr = req.wr && hit_ptr;
    data_wr = req.wr && hit_data;
  end

  // Mode word keeps every bit as written, reserved ones included
  // Reserved bits are the host's duty; storing them keeps read-back honest
  always_comb begin
    next_mode_reg = mode_reg;
    if (mode_wr) begin
      next_mode_reg = req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_reg <= `DMIS_RST_MODE;
    end else begin
      mode_reg <= next_mode_reg;
    end
  end

  // Interface word: only the four enables are stored
  always_comb begin
    next_iface_reg = iface_reg;
    if (iface_wr) begin
      next_iface_reg = req.wdata & `DMIS_IFACE_MASK; // Don't-care bits stay zero
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      iface_reg <= `DMIS_RST_IFACE;
    end else begin
      iface_reg <= next_iface_reg;
    end
  end

  // Pointer: a host write wins over the step after a data write
  // Both cannot meet in one cycle, since one request has one address
  always_comb begin
    next_ptr = ptr;
    if (ptr_wr) begin
      next_ptr = req.wdata[AW-1:0];
    end else if (data_wr) begin
      next_ptr = ptr + 1'b1; // Wraps at the top of memory
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr <= AW'(`DMIS_RST_PTR);
    end else begin
      ptr <= next_ptr;
    end
  end

  // Scratch memory: one write enable per word
  // No reset on the words keeps the array cheap; unwritten words read unknown
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
      always_comb begin
        word_we[i] = data_wr && (ptr == AW'(i));
      end
      always_ff @(posedge mclk) begin
        if (word_we[i]) begin
          mem[i] <= req.wdata;
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses and misses read as zero
  always_comb begin
    next_rdata = 16'h0000;
    if (req.rd) begin
      if (hit_mode) begin
        next_rdata = mode_reg;
      end else if (hit_iface) begin
        next_rdata = iface_reg;
      end else if (hit_ptr) begin
        next_rdata = {{(16-AW){1'b0}}, ptr};
      end else if (hit_data) begin
        next_rdata = mem[ptr];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Bus answer strobes, one cycle after the request
  always_comb begin
    next_rvalid = req.rd;
    next_ack = req.wr || req.rd; // Unmapped requests are answered too
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid <= 1'b0;
      ack <= 1'b0;
    end else begin
      rvalid <= next_rvalid;
      ack <= next_ack;
    end
  end

  // Control levels handed to the rest of the device
  always_comb begin
    next_ctrl.low_power_select = mode_reg[`DMIS_LOWPWR_BIT];
    next_ctrl.timeout_active = iface_reg[`DMIS_TIMEOUT_BIT];
    next_ctrl.pmbus_active = iface_reg[`DMIS_PMBUS_BIT];
    next_ctrl.fast_serial_out_enable = iface_reg[`DMIS_FSDO_BIT];
    next_ctrl.serial_out_enable = iface_reg[`DMIS_SDO_BIT];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // GPIO drives serial data only when enabled; otherwise released
  // Data is gated too, so a released pin never shows stale bits
  always_comb begin
    next_gpio_oe = iface_reg[`DMIS_SDO_BIT];
    next_gpio_out = iface_reg[`DMIS_SDO_BIT] & serial_out_line;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gpio_oe <= 1'b0;
    end else begin
      gpio_oe <= next_gpio_oe;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gpio_out <= 1'b0;
    end else begin
      gpio_out <= next_gpio_out;
    end
  end

  // Pin edge tracker; resets high, so a pin already low when reset ends looks like a fall
  always_comb begin
    next_gpio_q = gpio_in;
    protect_armed = gpi_enable && (gpi_function == `DMIS_GPI_PROTECT);
    pin_fall = gpio_q && !gpio_in;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gpio_q <= 1'b1;
    end else begin
      gpio_q <= next_gpio_q;
    end
  end

  // Safe-state command; mode bits are taken at the edge that sees the fall
  // A high level or a rising edge leaves the command idle
  always_comb begin
    action = dmis_safe_t'(mode_reg[`DMIS_PROT_HI:`DMIS_PROT_LO]);
    next_safe_cmd = '0;
    if (protect_armed && pin_fall) begin
      next_safe_cmd.fire = 1'b1;
      unique case (action)
        DMIS_SAFE_HIZ: next_safe_cmd.hiz_now = 1'b1;
        DMIS_SAFE_NVM: next_safe_cmd.jump_nvm = 1'b1;
        DMIS_SAFE_MLOW: next_safe_cmd.slew_low = 1'b1;
        DMIS_SAFE_MHIGH: next_safe_cmd.slew_high = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      safe_cmd <= '0;
    end else begin
      safe_cmd <= next_safe_cmd;
    end
  end

endmodule
